// File: include/risc8_consts.svh
/*
 * constants for the 8-bit core datapath: widths, data-space map, status
 * layout, reset values, timing and the instruction field codes.
 * assumes: included by bare name from the design files; the package does not include it.
 */
`ifndef RISC8_CONSTS_SVH
`define RISC8_CONSTS_SVH

// ----------------------------------------------------------------
// widths and sizes
// ----------------------------------------------------------------
`define DATA_W 8
`define INSN_W 12
`define PADDR_W 11
`define PMEM_WORDS 2048
`define PMEM_SMALL_WORDS 512
`define FADDR_W 5
`define RAM_WORDS 32
`define NIBBLE_MSB 3

// ----------------------------------------------------------------
// timing: 10 MHz clock, 200 ns instruction cycle
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define INSN_CYCLE_NS 200
`define INSN_CYCLE_CLKS (`INSN_CYCLE_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// data-space map of the special function registers
// ----------------------------------------------------------------
`define SFR_INDIRECT 5'h00
`define SFR_PCL 5'h02
`define SFR_STATUS 5'h03
`define SFR_FSR 5'h04
`define SFR_OUT_PORT 5'h05
`define SFR_IN_PORT 5'h06

// ----------------------------------------------------------------
// status register layout and reset values
// ----------------------------------------------------------------
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_ZERO 2
`define ST_PAGE_LO 5
`define ST_PAGE_HI 6
`define ST_WRITE_MASK 8'h63
`define STATUS_RESET 8'h00
`define BYTE_ZERO 8'h00
`define RESET_VECTOR 11'h000
`define NOP_WORD 12'h000

// ----------------------------------------------------------------
// instruction fields
// ----------------------------------------------------------------
`define F_OP6_HI 11
`define F_OP6_LO 6
`define F_DEST 5
`define F_BIT_HI 7
`define F_BIT_LO 5
`define F_LIT_HI 7
`define F_GOTO_HI 8
`define GRP_FILE 2'h0
`define OP_MOVWF 6'h00
`define OP_CLR 6'h01
`define OP_SUB 6'h02
`define OP_DEC 6'h03
`define OP_IOR 6'h04
`define OP_AND 6'h05
`define OP_XOR 6'h06
`define OP_ADD 6'h07
`define OP_MOV 6'h08
`define OP_COM 6'h09
`define OP_INC 6'h0a
`define OP_DECSZ 6'h0b
`define OP_RR 6'h0c
`define OP_RL 6'h0d
`define OP_SWAP 6'h0e
`define OP_INCSZ 6'h0f
`define OP4_BCF 4'h4
`define OP4_BSF 4'h5
`define OP4_BTFSC 4'h6
`define OP4_BTFSS 4'h7
`define OP3_GOTO 3'h5
`define OP4_MOVLW 4'hc
`define OP4_IORLW 4'hd
`define OP4_ANDLW 4'he
`define OP4_XORLW 4'hf

`endif

// File: include/risc8_pkg.sv
/*
 * types shared by the core datapath and its alu.
 * assumes: compiled before the design files.
 */
package risc8_pkg;

	// ----------------------------------------------------------------
	// alu operations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		alu_pass_f = 4'h0,
		alu_pass_w = 4'h1,
		alu_add = 4'h2,
		alu_sub = 4'h3,
		alu_and = 4'h4,
		alu_ior = 4'h5,
		alu_xor = 4'h6,
		alu_com = 4'h7,
		alu_inc = 4'h8,
		alu_dec = 4'h9,
		alu_rr = 4'ha,
		alu_rl = 4'hb,
		alu_swap = 4'hc,
		alu_clr = 4'hd,
		alu_bclr = 4'he,
		alu_bset = 4'hf
	} alu_op_e;

	// ----------------------------------------------------------------
	// pipeline slot state: normal execute or flushed slot
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		st_run = 2'b01,
		st_flush = 2'b10
	} pipe_state_e;

endpackage : risc8_pkg

// File: hw/risc8_alu.sv
/*
 * 8-bit two's complement alu with carry, nibble carry and zero outputs.
 * assumes: purely combinational; the caller picks which flags to keep.
 */
`timescale 1ns/1ps
`include "risc8_consts.svh"

module risc8_alu (
	// operands
	input wire logic [`DATA_W-1:0] operand_f,
	input wire logic [`DATA_W-1:0] operand_w,
	input wire logic carry_in,
	input wire logic [2:0] bit_sel,
	input wire risc8_pkg::alu_op_e op,
	// results
	output logic [`DATA_W-1:0] result,
	output logic carry_out,
	output logic nibble_out,
	output logic zero_out
);

	// ----------------------------------------------------------------
	// adder shared by add, subtract (f + ~w + 1)
	// ----------------------------------------------------------------
	logic [`DATA_W:0] sum; // carry in the top bit
	logic [`NIBBLE_MSB+1:0] low_sum; // low nibble with its carry
	logic [`DATA_W-1:0] addend; // w or its complement
	logic add_cin; // 1 for subtract
	logic [`DATA_W-1:0] bit_mask; // one-hot bit select

	// operand selection and the sums
	always_comb begin
		addend = (op == risc8_pkg::alu_sub) ? ~operand_w : operand_w; // [RULE7]
		add_cin = (op == risc8_pkg::alu_sub);
		sum = {1'b0, operand_f} + {1'b0, addend} + {{`DATA_W{1'b0}}, add_cin};
		low_sum = {1'b0, operand_f[`NIBBLE_MSB:0]} + {1'b0, addend[`NIBBLE_MSB:0]}
			+ {{(`NIBBLE_MSB+1){1'b0}}, add_cin};
		bit_mask = 8'h01 << bit_sel;
	end

	// ----------------------------------------------------------------
	// result and flags
	// ----------------------------------------------------------------
	always_comb begin
		carry_out = carry_in;
		nibble_out = low_sum[`NIBBLE_MSB+1]; // [RULE12] [RULE14]
		unique case (op)
			risc8_pkg::alu_pass_f: result = operand_f;
			risc8_pkg::alu_pass_w: result = operand_w;
			risc8_pkg::alu_add, risc8_pkg::alu_sub: begin
				result = sum[`DATA_W-1:0]; // [RULE6]
				carry_out = sum[`DATA_W]; // [RULE12]
			end
			risc8_pkg::alu_and: result = operand_f & operand_w;
			risc8_pkg::alu_ior: result = operand_f | operand_w;
			risc8_pkg::alu_xor: result = operand_f ^ operand_w;
			risc8_pkg::alu_com: result = ~operand_f;
			risc8_pkg::alu_inc: result = operand_f + 8'h01;
			risc8_pkg::alu_dec: result = operand_f - 8'h01;
			risc8_pkg::alu_rr: begin
				result = {carry_in, operand_f[`DATA_W-1:1]}; // [RULE6]
				carry_out = operand_f[0];
			end
			risc8_pkg::alu_rl: begin
				result = {operand_f[`DATA_W-2:0], carry_in};
				carry_out = operand_f[`DATA_W-1];
			end
			risc8_pkg::alu_swap: result = {operand_f[`NIBBLE_MSB:0], operand_f[`DATA_W-1:`NIBBLE_MSB+1]};
			risc8_pkg::alu_clr: result = `BYTE_ZERO;
			risc8_pkg::alu_bclr: result = operand_f & ~bit_mask;
			risc8_pkg::alu_bset: result = operand_f | bit_mask;
		endcase
		zero_out = (result == `BYTE_ZERO); // [RULE14]
	end

endmodule : risc8_alu

// File: hw/risc8_core_datapath.sv
/*
 * 8-bit harvard core datapath: program memory, two-stage pipeline,
 * working register, file registers with mapped special registers, alu.
 * assumes: program loaded through the load port while the core runs or
 * sits in reset; load port and in_port pins as described in ports.
 */
`timescale 1ns/1ps
`include "risc8_consts.svh"

// What this block does
// RULE1: one cycle per instruction, branches take two
// RULE2: whole 12-bit word fetched on own bus
// RULE3: fetch next word while current executes
// RULE4: internal 12-bit program memory, 512 or 2K; this block builds the 2K size only
// RULE5: special registers and program counter in data space
// RULE6: 8-bit alu: add, subtract, shift, logic
// RULE7: arithmetic in two's complement
// RULE8: two operands: working register plus file or literal
// RULE9: one operand: working register or file
// RULE10: working register 8 bits, not addressable
// RULE11: alu updates carry, nibble carry, zero flags
// RULE12: subtract: carry and nibble carry mean borrow
// RULE13: instruction cycle of 200 ns
// RULE14: add: nibble carry from bit 3; zero flag
module risc8_core_datapath (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// program memory load port, same clock domain
	input wire logic load_en,
	input wire logic [`PADDR_W-1:0] load_addr,
	input wire logic [`INSN_W-1:0] load_word,
	// input port pins, asynchronous
	input wire logic [`DATA_W-1:0] in_port,
	// observed core state
	output logic [`DATA_W-1:0] out_port,
	output logic [`DATA_W-1:0] working_reg,
	output logic [`PADDR_W-1:0] program_counter,
	output logic [`DATA_W-1:0] status_flags,
	output logic retired
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [`INSN_W-1:0] pmem [`PMEM_WORDS]; // program words [RULE4]
	logic [`DATA_W-1:0] ram [`RAM_WORDS]; // general file registers
	logic [`DATA_W-1:0] in_meta_q; // first sync stage
	logic [`DATA_W-1:0] in_sync_q; // second sync stage

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [1:0] cnt_q, cnt_d; // instruction cycle divider
	logic cycle_en; // one pulse per instruction cycle
	risc8_pkg::pipe_state_e state_q, state_d;
	logic [`PADDR_W-1:0] pc_q, pc_d; // address being fetched
	logic [`INSN_W-1:0] ir_q, ir_d; // word being executed
	logic [`DATA_W-1:0] w_q, w_d; // working register
	logic [`DATA_W-1:0] status_q, status_d;
	logic [`DATA_W-1:0] fsr_q, fsr_d; // indirect pointer
	logic [`DATA_W-1:0] port_q, port_d; // output port latch
	logic retired_q, retired_d; // pulse per executed slot

	// ----------------------------------------------------------------
	// decode results
	// ----------------------------------------------------------------
	risc8_pkg::alu_op_e alu_op;
	logic use_literal; // second operand is the literal
	logic wr_w; // result to working register
	logic wr_file; // result to file register
	logic upd_c, upd_dc, upd_z; // flags this instruction keeps
	logic skip_if_zero; // increment/decrement and skip
	logic skip_bit_clr, skip_bit_set; // bit tests
	logic is_goto;
	logic [`FADDR_W-1:0] ea; // effective file address
	logic [`DATA_W-1:0] file_val; // file operand read
	logic [`DATA_W-1:0] alu_f; // first alu operand
	logic [`DATA_W-1:0] alu_res;
	logic alu_c, alu_dc, alu_z;
	logic take_branch; // flush the fetched word
	logic [5:0] op6;
	logic [3:0] op4;

	// ----------------------------------------------------------------
	// input pin synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			in_meta_q <= `BYTE_ZERO;
			in_sync_q <= `BYTE_ZERO;
		end else begin
			in_meta_q <= in_port;
			in_sync_q <= in_meta_q;
		end
	end

	// program memory write port, separate from the data side
	always_ff @(posedge clock) begin
		if (load_en) begin
			pmem[load_addr] <= load_word; // [RULE4]
		end
	end

	// ----------------------------------------------------------------
	// instruction cycle divider, 200 ns from the 100 ns clock
	// ----------------------------------------------------------------
	always_comb begin
		cycle_en = (cnt_q == 2'(`INSN_CYCLE_CLKS - 1)); // [RULE13]
		cnt_d = cycle_en ? 2'h0 : cnt_q + 2'h1;
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			cnt_q <= 2'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// operand addressing and file read
	// ----------------------------------------------------------------
	always_comb begin
		op6 = ir_q[`F_OP6_HI:`F_OP6_LO];
		op4 = ir_q[`F_OP6_HI:`F_OP6_HI-3];
		// indirect slot reaches the file through the pointer [RULE5]
		ea = (ir_q[`FADDR_W-1:0] == `SFR_INDIRECT) ? fsr_q[`FADDR_W-1:0] : ir_q[`FADDR_W-1:0];
		unique case (ea)
			`SFR_INDIRECT: file_val = `BYTE_ZERO; // pointer at itself reads zero
			`SFR_PCL: file_val = pc_q[`DATA_W-1:0]; // [RULE5]
			`SFR_STATUS: file_val = status_q;
			`SFR_FSR: file_val = fsr_q;
			`SFR_OUT_PORT: file_val = port_q;
			`SFR_IN_PORT: file_val = in_sync_q;
			default: file_val = ram[ea];
		endcase
		alu_f = use_literal ? ir_q[`F_LIT_HI:0] : file_val; // [RULE8]
	end

	// ----------------------------------------------------------------
	// instruction decode
	// ----------------------------------------------------------------
	always_comb begin
		alu_op = risc8_pkg::alu_pass_f;
		use_literal = 1'b0;
		wr_w = 1'b0;
		wr_file = 1'b0;
		upd_c = 1'b0;
		upd_dc = 1'b0;
		upd_z = 1'b0;
		skip_if_zero = 1'b0;
		skip_bit_clr = 1'b0;
		skip_bit_set = 1'b0;
		is_goto = 1'b0;
		if (ir_q[`F_OP6_HI:`F_OP6_HI-1] == `GRP_FILE) begin
			// file group: destination bit picks w or file [RULE9]
			wr_w = !ir_q[`F_DEST];
			wr_file = ir_q[`F_DEST];
			upd_z = 1'b1;
			unique case (op6)
				`OP_MOVWF: begin
					alu_op = risc8_pkg::alu_pass_w; // dest clear is no-op
					wr_w = 1'b0;
					upd_z = 1'b0;
				end
				`OP_CLR: alu_op = risc8_pkg::alu_clr;
				`OP_SUB: begin
					alu_op = risc8_pkg::alu_sub; // [RULE12]
					upd_c = 1'b1;
					upd_dc = 1'b1;
				end
				`OP_ADD: begin
					alu_op = risc8_pkg::alu_add; // [RULE14]
					upd_c = 1'b1;
					upd_dc = 1'b1;
				end
				`OP_DEC: alu_op = risc8_pkg::alu_dec;
				`OP_IOR: alu_op = risc8_pkg::alu_ior;
				`OP_AND: alu_op = risc8_pkg::alu_and;
				`OP_XOR: alu_op = risc8_pkg::alu_xor;
				`OP_MOV: alu_op = risc8_pkg::alu_pass_f;
				`OP_COM: alu_op = risc8_pkg::alu_com;
				`OP_INC: alu_op = risc8_pkg::alu_inc;
				`OP_DECSZ, `OP_INCSZ: begin
					alu_op = (op6 == `OP_DECSZ) ? risc8_pkg::alu_dec : risc8_pkg::alu_inc;
					upd_z = 1'b0;
					skip_if_zero = 1'b1;
				end
				`OP_RR, `OP_RL: begin
					alu_op = (op6 == `OP_RR) ? risc8_pkg::alu_rr : risc8_pkg::alu_rl;
					upd_z = 1'b0;
					upd_c = 1'b1;
				end
				`OP_SWAP: begin
					alu_op = risc8_pkg::alu_swap;
					upd_z = 1'b0;
				end
				default: begin
					wr_w = 1'b0; // unused codes act as no-op
					wr_file = 1'b0;
					upd_z = 1'b0;
				end
			endcase
		end else if (ir_q[`F_OP6_HI:`F_OP6_HI-2] == `OP3_GOTO) begin
			is_goto = 1'b1; // [RULE1]
		end else begin
			unique case (op4)
				`OP4_BCF: begin
					alu_op = risc8_pkg::alu_bclr;
					wr_file = 1'b1;
				end
				`OP4_BSF: begin
					alu_op = risc8_pkg::alu_bset;
					wr_file = 1'b1;
				end
				`OP4_BTFSC: skip_bit_clr = 1'b1;
				`OP4_BTFSS: skip_bit_set = 1'b1;
				`OP4_MOVLW, `OP4_IORLW, `OP4_ANDLW, `OP4_XORLW: begin
					use_literal = 1'b1; // [RULE8]
					wr_w = 1'b1;
					upd_z = (op4 != `OP4_MOVLW);
					unique case (op4)
						`OP4_IORLW: alu_op = risc8_pkg::alu_ior;
						`OP4_ANDLW: alu_op = risc8_pkg::alu_and;
						`OP4_XORLW: alu_op = risc8_pkg::alu_xor;
						default: alu_op = risc8_pkg::alu_pass_f;
					endcase
				end
				default: alu_op = risc8_pkg::alu_pass_f; // reserved codes: no-op
			endcase
		end
	end

	// ----------------------------------------------------------------
	// alu
	// ----------------------------------------------------------------
	risc8_alu u_alu (
		.operand_f(alu_f),
		.operand_w(w_q),
		.carry_in(status_q[`ST_CARRY]),
		.bit_sel(ir_q[`F_BIT_HI:`F_BIT_LO]),
		.op(alu_op),
		.result(alu_res),
		.carry_out(alu_c),
		.nibble_out(alu_dc),
		.zero_out(alu_z)
	);

	// ----------------------------------------------------------------
	// execute one slot per instruction cycle, fetch in parallel
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		pc_d = pc_q;
		ir_d = ir_q;
		w_d = w_q;
		status_d = status_q;
		fsr_d = fsr_q;
		port_d = port_q;
		retired_d = 1'b0;
		take_branch = 1'b0;
		if (cycle_en) begin
			ir_d = pmem[pc_q]; // whole word in one cycle [RULE2] [RULE3]
			pc_d = pc_q + 11'h001;
			state_d = risc8_pkg::st_run;
			if (state_q == risc8_pkg::st_run) begin
				retired_d = 1'b1; // [RULE1]
				// flags first, so an explicit status write overrides them
				if (upd_c) status_d[`ST_CARRY] = alu_c; // [RULE11] [RULE12]
				if (upd_dc) status_d[`ST_NIBBLE] = alu_dc; // [RULE11] [RULE14]
				if (upd_z) status_d[`ST_ZERO] = alu_z; // [RULE11] [RULE14]
				if (wr_w) w_d = alu_res; // [RULE10]
				if (wr_file) begin
					unique case (ea)
						`SFR_PCL: begin
							// write to the counter is a branch [RULE5]
							pc_d = {status_q[`ST_PAGE_HI:`ST_PAGE_LO], 1'b0, alu_res};
							take_branch = 1'b1;
						end
						`SFR_STATUS: status_d = alu_res & `ST_WRITE_MASK;
						`SFR_FSR: fsr_d = alu_res;
						`SFR_OUT_PORT: port_d = alu_res;
						default: ; // ram, input port and indirect slot
					endcase
				end
				if (is_goto) begin
					pc_d = {status_q[`ST_PAGE_HI:`ST_PAGE_LO], ir_q[`F_GOTO_HI:0]};
					take_branch = 1'b1;
				end
				// skips discard the word fetched now
				if ((skip_if_zero && alu_z) || (skip_bit_clr && !file_val[ir_q[`F_BIT_HI:`F_BIT_LO]])
					|| (skip_bit_set && file_val[ir_q[`F_BIT_HI:`F_BIT_LO]])) begin
					take_branch = 1'b1;
				end
				if (take_branch) begin
					state_d = risc8_pkg::st_flush; // second cycle of branch [RULE1]
				end
			end
		end
	end

	// general file writes
	always_ff @(posedge clock) begin
		if (cycle_en && state_q == risc8_pkg::st_run && wr_file && ea > `SFR_IN_PORT) begin
			ram[ea] <= alu_res;
		end
	end

	// pipeline and core registers
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_q <= risc8_pkg::st_flush; // first slot only fetches
			pc_q <= `RESET_VECTOR;
			ir_q <= `NOP_WORD;
			w_q <= `BYTE_ZERO;
			status_q <= `STATUS_RESET;
			fsr_q <= `BYTE_ZERO;
			port_q <= `BYTE_ZERO;
			retired_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pc_q <= pc_d;
			ir_q <= ir_d;
			w_q <= w_d;
			status_q <= status_d;
			fsr_q <= fsr_d;
			port_q <= port_d;
			retired_q <= retired_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs straight from flops
	// ----------------------------------------------------------------
	assign out_port = port_q;
	assign working_reg = w_q;
	assign program_counter = pc_q;
	assign status_flags = status_q;
	assign retired = retired_q;

endmodule : risc8_core_datapath

// File: dv/risc8_core_properties.sv
/*
 * concurrent checks on the core datapath ports.
 * assumes: bound to risc8_core_datapath; one clock, nrst active low.
 */
`timescale 1ns/1ps
`include "risc8_consts.svh"

module risc8_core_properties (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// load port and pins
	input wire logic load_en,
	input wire logic [`PADDR_W-1:0] load_addr,
	input wire logic [`INSN_W-1:0] load_word,
	input wire logic [`DATA_W-1:0] in_port,
	// observed state
	input wire logic [`DATA_W-1:0] out_port,
	input wire logic [`DATA_W-1:0] working_reg,
	input wire logic [`PADDR_W-1:0] program_counter,
	input wire logic [`DATA_W-1:0] status_flags,
	input wire logic retired
);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking

	a_reset_clears_state: assert property (!nrst |=> working_reg == 8'h00 && out_port == 8'h00 &&
		program_counter == 11'h000 && status_flags == 8'h00 && !retired) else $error("state not cleared by reset");
	a_retire_one_clock: assert property (disable iff (!nrst) retired |=> !retired)
		else $error("retire pulse longer than one clock");
	a_first_retire_bound: assert property (disable iff (!nrst) $rose(nrst) |-> ##[2:6] retired)
		else $error("no instruction retired after reset release");
	a_w_needs_retire: assert property (disable iff (!nrst) $past(nrst) && $changed(working_reg) |-> retired)
		else $error("working register moved without an instruction");
	a_flags_need_retire: assert property (disable iff (!nrst) $past(nrst) && $changed(status_flags) |-> retired)
		else $error("status moved without an instruction");
	a_out_needs_retire: assert property (disable iff (!nrst) $past(nrst) && $changed(out_port) |-> retired)
		else $error("out port moved without an instruction");
	a_status_spare_zero: assert property (disable iff (!nrst) status_flags[7] == 1'b0 && status_flags[4:3] == 2'b00)
		else $error("unused status bits set");
	a_pc_two_clocks: assert property (disable iff (!nrst) $past(nrst) && $changed(program_counter)
		|=> $stable(program_counter)) else $error("program counter moved twice within one cycle");
endmodule : risc8_core_properties

bind risc8_core_datapath risc8_core_properties u_risc8_core_properties (.clock(clock), .nrst(nrst),
	.load_en(load_en), .load_addr(load_addr), .load_word(load_word), .in_port(in_port), .out_port(out_port),
	.working_reg(working_reg), .program_counter(program_counter), .status_flags(status_flags), .retired(retired));

// File: dv/prog_loader.sv
/*
 * program memory loader standing in for the programming side.
 * assumes: same clock as the core; words written one per strobe.
 */
`timescale 1ns/1ps
`include "risc8_consts.svh"

module prog_loader (
	// clock
	input wire logic clock,
	// load port toward the core
	output logic load_en,
	output logic [`PADDR_W-1:0] load_addr,
	output logic [`INSN_W-1:0] load_word
);
	// idle at time zero
	initial begin
		load_en = 1'b0;
		load_addr = '0;
		load_word = '0;
	end

	// one word per strobe, held for one whole clock
	task automatic put_word(input logic [`PADDR_W-1:0] addr, input logic [`INSN_W-1:0] word);
		@(posedge clock);
		#1;
		load_en = 1'b1;
		load_addr = addr;
		load_word = word;
		@(posedge clock);
		#1;
		load_en = 1'b0;
		// released lines do not keep the last value
		load_addr = ~addr;
		load_word = ~word;
	endtask : put_word
endmodule : prog_loader

// File: dv/tb.sv
/*
 * self-checking bench: runs a short program per test, compares with a model.
 * assumes: core and loader compiled; checker bound to the core.
 */
`timescale 1ns/1ps

module tb;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] in_port = 8'h00;
	logic load_en;
	logic [10:0] load_addr;
	logic [11:0] load_word;
	logic [7:0] out_port, working_reg, status_flags;
	logic [10:0] program_counter;
	logic retired;
	int bad_count = 0;
	int n_compared = 0;
	// model state
	int prog [int];
	int ram [32];
	int m_w, m_c, m_dc, m_z, m_out, m_in, m_pc, exp_pc, was_branch;

	// 100 ns clock
	always #50 clock = ~clock;

	prog_loader u_prog_loader (.clock(clock), .load_en(load_en), .load_addr(load_addr), .load_word(load_word));

	risc8_core_datapath u_risc8_core_datapath (.clock(clock), .nrst(nrst), .load_en(load_en),
		.load_addr(load_addr), .load_word(load_word), .in_port(in_port), .out_port(out_port),
		.working_reg(working_reg), .program_counter(program_counter), .status_flags(status_flags),
		.retired(retired));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	// store in the model image and in the core
	task automatic put(input int addr, input int word);
		prog[addr] = word;
		u_prog_loader.put_word(11'(addr), 12'(word));
	endtask : put

	// bounded wait for the next retire pulse, counting clocks
	task automatic wait_retire(output int gap);
		gap = 0;
		do begin
			@(negedge clock);
			gap++;
		end while (retired !== 1'b1 && gap < 12);
		if (retired !== 1'b1) begin
			check({11'h000, retired}, 12'h001);
			tally_and_finish();
		end
	endtask : wait_retire

	// reference model: one instruction from the image
	task automatic model_step();
		int w, f, fv, r, op, d;
		w = prog[m_pc];
		exp_pc = m_pc + 2;
		was_branch = 0;
		if (w >= 'hc00) begin
			// literal group
			r = w & 'hff;
			case ((w >> 8) & 3)
				0: m_w = r;
				1: m_w = m_w | r;
				2: m_w = m_w & r;
				default: m_w = m_w ^ r;
			endcase
			if (w >= 'hd00) m_z = (m_w == 0);
			m_pc++;
		end else if ((w >> 9) == 5) begin
			// goto: next slot flushed
			m_pc = w & 'h1ff;
			exp_pc = m_pc;
			was_branch = 1;
		end else if (w >= 'h400) begin
			// bit group: clear, set, test and skip
			f = w & 'h1f;
			d = 1 << ((w >> 5) & 7);
			op = (w >> 8) & 3;
			fv = (f == 5) ? m_out : (f == 6) ? m_in : ram[f];
			r = (op == 0) ? (fv & ~d) : (fv | d);
			if (op < 2 && f == 5) m_out = r;
			else if (op < 2) ram[f] = r;
			else if (((fv & d) != 0) == (op == 3)) begin
				// taken test flushes the next word
				m_pc++;
				was_branch = 1;
			end
			m_pc++;
		end else begin
			// file group
			f = w & 'h1f;
			d = (w >> 5) & 1;
			op = w >> 6;
			fv = (f == 5) ? m_out : (f == 6) ? m_in : ram[f];
			r = fv;
			case (op)
				0: r = m_w;
				1: r = 0;
				3, 11: r = (fv - 1) & 'hff;
				4: r = fv | m_w;
				5: r = fv & m_w;
				6: r = fv ^ m_w;
				9: r = ~fv & 'hff;
				10, 15: r = (fv + 1) & 'hff;
				12: begin
					r = (fv >> 1) | (m_c << 7);
					m_c = fv & 1;
				end
				14: r = ((fv << 4) | (fv >> 4)) & 'hff;
				2: begin
					r = (fv - m_w) & 'hff;
					m_c = fv >= m_w;
					m_dc = (fv & 15) >= (m_w & 15);
				end
				7: begin
					r = fv + m_w;
					m_c = r > 255;
					m_dc = (fv & 15) + (m_w & 15) > 15;
					r = r & 'hff;
				end
				13: begin
					r = ((fv << 1) | m_c) & 'hff;
					m_c = fv >> 7;
				end
				default: ;
			endcase
			if (op >= 1 && op <= 10) m_z = (r == 0);
			if ((op == 11 || op == 15) && r == 0) begin
				// counted skip flushes the next word
				m_pc++;
				was_branch = 1;
			end
			if (op == 0 || d == 1) begin
				if (f == 5) m_out = r;
				else ram[f] = r;
			end else begin
				m_w = r;
			end
			m_pc++;
		end
	endtask : model_step

	// ----------------------------------------------------------------
	// one test: reset, load, run 40 retires
	// ----------------------------------------------------------------
	task automatic run_test(input int idx, input int a, input int b, input int k);
		int gap;
		int blk [21] = '{'h247, 'h2a7, 'h0e7, 'h107, 'h167, 'h187, 'h327, 'h387, 'h565, 'h405, 'h707,
			'hc5a, 'h607, 'hc3c, 'hc01, 'h028, 'h2e8, 'hcff, 'h3c7, 'h068, 'ha34};
		@(posedge clock);
		#1;
		nrst = 1'b0;
		in_port = 8'($urandom);
		m_in = in_port;
		prog.delete();
		put(0, 'hc00 | a);
		put(1, 'h027);
		put(2, 'hc00 | b);
		put(3, 'h1c7);
		put(4, 'h0a7);
		put(5, 'h207);
		put(6, 'h025);
		put(7, 'h347);
		put(8, 'hd00 | k);
		put(9, 'he00 | b);
		put(10, 'hf00 | a);
		put(11, 'hbf0);
		put('h1f0, 'h206);
		put('h1f1, 'h1e7);
		put('h1f2, 'h0a7);
		put('h1f3, 'h207);
		put('h1f4, 'ha20);
		// second block: remaining file ops, bit ops and skips
		foreach (blk[j]) put('h20 + j, blk[j]);
		repeat (4) @(posedge clock);
		#1;
		nrst = 1'b1;
		{m_w, m_c, m_dc, m_z, m_out, m_pc, was_branch} = '0;
		for (int n = 0; n < 40; n++) begin
			wait_retire(gap);
			if (n > 0) check(12'(gap), (was_branch != 0) ? 12'h004 : 12'h002);
			model_step();
			check({4'h0, working_reg}, 12'(m_w));
			check({4'h0, status_flags}, 12'(m_z * 4 + m_dc * 2 + m_c));
			check({4'h0, out_port}, 12'(m_out));
			check({1'b0, program_counter}, 12'(exp_pc));
		end
		$display("test %0d done", idx);
	endtask : run_test

	// ----------------------------------------------------------------
	// main sequence: boundary operands first, then random
	// ----------------------------------------------------------------
	initial begin
		static int ta [4] = '{'hff, 'h08, 'h00, 'h80};
		static int tbv [4] = '{'h01, 'h08, 'h00, 'h80};
		void'($urandom(15805));
		repeat (4) @(posedge clock);
		#1;
		nrst = 1'b1;
		for (int i = 0; i < 12; i++) begin
			if (i < 4) run_test(i, ta[i], tbv[i], i * 'h11);
			else run_test(i, $urandom % 256, $urandom % 256, $urandom % 256);
		end
		tally_and_finish();
	end
endmodule : tb
